//--- hw/aea_pkg.sv
// How it works
// - One power sample is added into the accumulator every four clock cycles.
// - The accumulator update is a signed addition; negative power lowers energy.
// - Power is divided by the 8-bit divider before accumulation; zero means one.
// - A 53-bit signed accumulator; its upper 24 bits form the energy window.
// - The accumulator's largest positive value is two to the 52 minus one.
// - The read-clear access returns the window, then zeroes the upper 24 bits.
// - The window wraps 7fffff to 800000 going up and 800000 to 7fffff going down.
// - Enabled half-full and overflow/underflow events drive the active-low interrupt.
// - Power waveform is routed out when mode bits are 00 and sample enable set.
// - Waveform rate selectable at 27.9, 14, 7 or 3.5 thousand samples per second.
// - The signed 16-bit power offset is added to the power signal.
// - 256 offset LSBs equal one waveform sample LSB.
// - One converter pulse per LSB accumulated into the energy window.
// - One calibration pulse per (denominator+1)/(numerator+1) converter pulses.
// - Numerator and denominator are unsigned 12-bit values.
// - A zero numerator or denominator is used as one.
// - A ratio above one is clamped to one.
// - Power is scaled by one plus the signed 12-bit gain over 4096.
`default_nettype none

package aea_pkg;
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 53;
  localparam int WIN_W = 24;
  localparam int WIN_LSB = 29;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 12;
  localparam int OFS_W = 16;
  localparam int OFS_SHIFT = 8;
  localparam int DIV_W = 8;
  localparam int PWR_W = 34;
  localparam int CF_W = 12;
  localparam int PEND_W = 8;
  localparam int ACC_PERIOD_CLKS = 4;
  localparam int CLK_HZ = 250_000_000;
  localparam int WAVE_RATE_HZ = 27_900;
  localparam int WAVE_PERIOD_CYC = CLK_HZ / WAVE_RATE_HZ;
  localparam int WAVE_CNT_W = 17;
  // Status and enable bit positions
  localparam int ST_HALF = 0;
  localparam int ST_OVF = 1;
  localparam int IEN_WAVEFORM_SAMPLE_IRQ_ENABLE = 3;
  localparam logic [WIN_W-1:0] WIN_POS_FULL = 24'h7fffff;
  localparam logic [WIN_W-1:0] WIN_NEG_FULL = 24'h800000;
  localparam logic [ACC_W-1:0] ACC_RST = 53'h0;
  localparam logic [1:0] ST_RST = 2'h0;
endpackage

`default_nettype wire

//--- hw/aea_pwr_cond.sv
`default_nettype none

module aea_pwr_cond (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic signed [aea_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic signed [aea_pkg::GAIN_W-1:0] gain_in,
  input wire logic signed [aea_pkg::OFS_W-1:0] offset_in,
  input wire logic [aea_pkg::DIV_W-1:0] div_in,
  output logic signed [aea_pkg::PWR_W-1:0] corr_out,
  output logic signed [aea_pkg::PWR_W-1:0] quot_out
);
  logic signed [aea_pkg::PWR_W-1:0] base_v;
  logic signed [aea_pkg::PWR_W+aea_pkg::GAIN_W-1:0] prod_v;
  logic signed [aea_pkg::PWR_W-1:0] gain_v;
  logic signed [aea_pkg::PWR_W-1:0] divisor_v;
  logic signed [aea_pkg::PWR_W-1:0] corr_d;
  logic signed [aea_pkg::PWR_W-1:0] corr_q;
  logic signed [aea_pkg::PWR_W-1:0] quot_d;
  logic signed [aea_pkg::PWR_W-1:0] quot_q;

  ////////////////////////////////////////////////////////////////////////
  // Offset in 1/256 sample units, then gain, then divide
  always_comb begin
    base_v = (aea_pkg::PWR_W'(sample_in) <<< aea_pkg::OFS_SHIFT)
           + aea_pkg::PWR_W'(offset_in);
    prod_v = (aea_pkg::PWR_W+aea_pkg::GAIN_W)'(base_v)
           * (aea_pkg::PWR_W+aea_pkg::GAIN_W)'(gain_in);
    gain_v = base_v + aea_pkg::PWR_W'(prod_v >>> aea_pkg::GAIN_SHIFT);
    // Divider is tiny and fixed-point friendly; a full divide keeps one cycle latency
    divisor_v = (div_in == 8'h00) ? 34'sh1 : $signed({26'h0, div_in});
    corr_d = gain_v;
    quot_d = gain_v / divisor_v;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      corr_q <= '0;
      quot_q <= '0;
    end else begin
      corr_q <= corr_d;
      quot_q <= quot_d;
    end
  end

  assign corr_out = corr_q;
  assign quot_out = quot_q;

  ////////////////////////////////////////////////////////////////////////
  a_div_zero_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (div_in == 8'h00) |=> (quot_q == $past(gain_v)))
    else $error("zero divider not treated as one");
  a_gain_scale: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (gain_in == 12'sh0) |=> (corr_q == $past(base_v)))
    else $error("zero gain changed the power");
endmodule

`default_nettype wire

//--- hw/aea_top.sv
`default_nettype none

module aea_top #(
  parameter int WAVE_PERIOD_CYC = aea_pkg::WAVE_PERIOD_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic signed [aea_pkg::SAMPLE_W-1:0] PWR_SAMPLE_IN,
  input wire logic signed [aea_pkg::GAIN_W-1:0] POWER_GAIN_IN,
  input wire logic signed [aea_pkg::OFS_W-1:0] POWER_OFFSET_IN,
  input wire logic [aea_pkg::DIV_W-1:0] ENERGY_DIVIDER_IN,
  input wire logic [aea_pkg::CF_W-1:0] PULSE_NUMERATOR_IN,
  input wire logic [aea_pkg::CF_W-1:0] PULSE_DENOMINATOR_IN,
  input wire logic [1:0] MODE_WAVE_SEL_IN,
  input wire logic [1:0] WAVE_RATE_SEL_IN,
  input wire logic [3:0] IRQ_EN_IN,
  input wire logic [1:0] STATUS_CLR_IN,
  input wire logic READ_CLEAR_IN,
  output logic [aea_pkg::WIN_W-1:0] ACTIVE_ENERGY_OUT,
  output logic [1:0] STATUS_OUT,
  output logic IRQ_B_OUT,
  output logic CALIBRATION_PULSE_OUT,
  output logic [aea_pkg::SAMPLE_W-1:0] WAVE_DATA_OUT,
  output logic WAVE_VALID_OUT
);
  logic signed [aea_pkg::PWR_W-1:0] corr;
  logic signed [aea_pkg::PWR_W-1:0] quot;

  aea_pwr_cond u_cond (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .sample_in(PWR_SAMPLE_IN),
    .gain_in(POWER_GAIN_IN),
    .offset_in(POWER_OFFSET_IN),
    .div_in(ENERGY_DIVIDER_IN),
    .corr_out(corr),
    .quot_out(quot)
  );

  ////////////////////////////////////////////////////////////////////////
  // Accumulation tick and energy accumulator
  logic [1:0] tick_cnt_d;
  logic [1:0] tick_cnt_q;
  logic tick;
  logic signed [aea_pkg::ACC_W-1:0] sum_v;
  logic [aea_pkg::WIN_W-1:0] old_win;
  logic [aea_pkg::WIN_W-1:0] new_win;
  logic [aea_pkg::ACC_W-1:0] acc_d;
  logic [aea_pkg::ACC_W-1:0] acc_q;
  logic [aea_pkg::WIN_W-1:0] win_d;
  logic [aea_pkg::WIN_W-1:0] win_q;
  logic [1:0] st_set;
  logic [1:0] st_d;
  logic [1:0] st_q;
  logic irq_b_d;
  logic irq_b_q;

  assign tick = (tick_cnt_q == 2'(aea_pkg::ACC_PERIOD_CLKS - 1));

  always_comb begin
    tick_cnt_d = tick_cnt_q + 2'h1;
    sum_v = $signed(acc_q) + aea_pkg::ACC_W'(quot);
    old_win = acc_q[aea_pkg::ACC_W-1:aea_pkg::WIN_LSB];
    new_win = sum_v[aea_pkg::ACC_W-1:aea_pkg::WIN_LSB];
    acc_d = acc_q;
    if (tick) begin
      acc_d = sum_v;
    end
    // Clear after the add so a same-cycle sample keeps its low bits
    if (READ_CLEAR_IN) begin
      acc_d[aea_pkg::ACC_W-1:aea_pkg::WIN_LSB] = '0;
    end
    win_d = acc_d[aea_pkg::ACC_W-1:aea_pkg::WIN_LSB];
    st_set = 2'h0;
    if (tick) begin
      st_set[aea_pkg::ST_HALF] = (new_win[23] ^ new_win[22])
                               & ~(old_win[23] ^ old_win[22]);
      // Sign flip against the addend sign marks wrap past 2^52-1 or below -2^52
      st_set[aea_pkg::ST_OVF] = (~old_win[23] & new_win[23] & ~quot[aea_pkg::PWR_W-1])
                              | (old_win[23] & ~new_win[23] & quot[aea_pkg::PWR_W-1]);
    end
    st_d = (st_q & ~STATUS_CLR_IN) | st_set;
    irq_b_d = ~|(st_d & IRQ_EN_IN[1:0]);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tick_cnt_q <= 2'h0;
      acc_q <= aea_pkg::ACC_RST;
      win_q <= '0;
      st_q <= aea_pkg::ST_RST;
      irq_b_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      acc_q <= acc_d;
      win_q <= win_d;
      st_q <= st_d;
      irq_b_q <= irq_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Digital-to-frequency converter and calibration pulse scaling
  logic [aea_pkg::WIN_W-1:0] dlt_v;
  logic [aea_pkg::PEND_W:0] pend_v;
  logic [aea_pkg::PEND_W-1:0] pend_d;
  logic [aea_pkg::PEND_W-1:0] pend_q;
  logic dfc_pulse;
  logic [aea_pkg::CF_W:0] np1_v;
  logic [aea_pkg::CF_W:0] dp1_v;
  logic [aea_pkg::CF_W+1:0] frac_v;
  logic [aea_pkg::CF_W+1:0] frac_d;
  logic [aea_pkg::CF_W+1:0] frac_q;
  logic cf_d;
  logic cf_q;

  assign dfc_pulse = (pend_q != '0);

  always_comb begin
    // Magnitude of window movement, ignoring the read-clear jump
    dlt_v = new_win - old_win;
    if (quot[aea_pkg::PWR_W-1]) begin
      dlt_v = old_win - new_win;
    end
    pend_v = {1'b0, pend_q} - {{aea_pkg::PEND_W{1'b0}}, dfc_pulse};
    if (tick) begin
      pend_v = pend_v + (aea_pkg::PEND_W+1)'(dlt_v);
    end
    // Saturate; only reachable with extreme power and tiny divider
    pend_d = pend_v[aea_pkg::PEND_W] ? '1 : pend_v[aea_pkg::PEND_W-1:0];
    np1_v = {1'b0, PULSE_NUMERATOR_IN} + 13'h1;
    if (PULSE_NUMERATOR_IN == 12'h000) begin
      np1_v = 13'h2;
    end
    dp1_v = {1'b0, PULSE_DENOMINATOR_IN} + 13'h1;
    if (PULSE_DENOMINATOR_IN == 12'h000) begin
      dp1_v = 13'h2;
    end
    if (np1_v > dp1_v) begin
      np1_v = dp1_v;
    end
    frac_d = frac_q;
    cf_d = 1'b0;
    frac_v = frac_q + {1'b0, np1_v};
    if (dfc_pulse) begin
      if (frac_v >= {1'b0, dp1_v}) begin
        frac_d = frac_v - {1'b0, dp1_v};
        cf_d = 1'b1;
      end else begin
        frac_d = frac_v;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pend_q <= '0;
      frac_q <= '0;
      cf_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      frac_q <= frac_d;
      cf_q <= cf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Waveform sample routing
  logic route;
  logic [aea_pkg::WAVE_CNT_W-1:0] wave_period_v;
  logic [aea_pkg::WAVE_CNT_W-1:0] wave_cnt_d;
  logic [aea_pkg::WAVE_CNT_W-1:0] wave_cnt_q;
  logic wave_vld_d;
  logic wave_vld_q;
  logic [aea_pkg::SAMPLE_W-1:0] wave_dat_d;
  logic [aea_pkg::SAMPLE_W-1:0] wave_dat_q;

  assign route = (MODE_WAVE_SEL_IN == 2'h0) && IRQ_EN_IN[aea_pkg::IEN_WAVEFORM_SAMPLE_IRQ_ENABLE];

  always_comb begin
    wave_period_v = aea_pkg::WAVE_CNT_W'(WAVE_PERIOD_CYC) << WAVE_RATE_SEL_IN;
    wave_cnt_d = wave_cnt_q + 17'h1;
    wave_vld_d = 1'b0;
    wave_dat_d = wave_dat_q;
    if (wave_cnt_q >= wave_period_v - 17'h1) begin
      wave_cnt_d = '0;
      wave_vld_d = route;
      if (route) begin
        wave_dat_d = corr[aea_pkg::SAMPLE_W+aea_pkg::OFS_SHIFT-1:aea_pkg::OFS_SHIFT];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wave_cnt_q <= '0;
      wave_vld_q <= 1'b0;
      wave_dat_q <= '0;
    end else begin
      wave_cnt_q <= wave_cnt_d;
      wave_vld_q <= wave_vld_d;
      wave_dat_q <= wave_dat_d;
    end
  end

  assign ACTIVE_ENERGY_OUT = win_q;
  assign STATUS_OUT = st_q;
  assign IRQ_B_OUT = irq_b_q;
  assign CALIBRATION_PULSE_OUT = cf_q;
  assign WAVE_DATA_OUT = wave_dat_q;
  assign WAVE_VALID_OUT = wave_vld_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  a_tick_spacing: assert property (
    tick |=> !tick [*3] ##1 tick)
    else $error("accumulation tick not every four cycles");
  a_signed_add: assert property (
    tick && !READ_CLEAR_IN |=> acc_q == $past(acc_q) + 53'($past(quot)))
    else $error("accumulator not a signed add of the sample");
  a_window_upper: assert property (
    ACTIVE_ENERGY_OUT == acc_q[aea_pkg::ACC_W-1:aea_pkg::WIN_LSB])
    else $error("window is not the upper accumulator bits");
  a_read_clear: assert property (
    READ_CLEAR_IN && !tick |=> ACTIVE_ENERGY_OUT == 24'h0 ##0 acc_q[28:0] == $past(acc_q[28:0]))
    else $error("read-clear did not clear only the upper bits");
  a_wrap_flag: assert property (
    ($past(win_q) == aea_pkg::WIN_POS_FULL && win_q == aea_pkg::WIN_NEG_FULL)
      |-> st_q[aea_pkg::ST_OVF])
    else $error("positive wrap did not raise overflow");
  a_irq_level: assert property (
    ##1 IRQ_B_OUT == !(|(st_q & $past(IRQ_EN_IN[1:0]))))
    else $error("interrupt output disagrees with enabled flags");
  a_flag_sticky: assert property (
    st_q[aea_pkg::ST_HALF] && !STATUS_CLR_IN[aea_pkg::ST_HALF] |=> st_q[aea_pkg::ST_HALF])
    else $error("half-full flag dropped without a clear");
  a_cf_source: assert property (
    CALIBRATION_PULSE_OUT |-> $past(dfc_pulse))
    else $error("calibration pulse without a converter pulse");
  a_cf_ratio: assert property (
    PULSE_NUMERATOR_IN == 12'h0 && PULSE_DENOMINATOR_IN == 12'h0 && dfc_pulse
      |=> CALIBRATION_PULSE_OUT)
    else $error("unity ratio dropped a pulse");
  a_wave_route: assert property (
    WAVE_VALID_OUT |-> $past(route))
    else $error("waveform sample emitted while not routed");

  c_wrap: cover property ($past(win_q) == aea_pkg::WIN_POS_FULL && win_q == aea_pkg::WIN_NEG_FULL);
  c_cf: cover property (CALIBRATION_PULSE_OUT);
  c_wave: cover property (WAVE_VALID_OUT);
  c_rdclr: cover property (READ_CLEAR_IN && tick);
endmodule

`default_nettype wire

//--- tb/aea_cal_counter.sv
`default_nettype none

module aea_cal_counter (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pulse_in,
  output var int count_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Meter-side counter with no width filter, so a one-cycle pulse counts
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= 0;
    end else if (pulse_in) begin
      count_out <= count_out + 1;
    end
  end
endmodule

`default_nettype wire

//--- tb/aea_top_tb.sv
`default_nettype none

module aea_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WP = 16;
  localparam int K = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic signed [23:0] smp = '0;
  logic signed [11:0] gain = '0;
  logic signed [15:0] ofs = '0;
  logic [7:0] dv = 8'h01;
  logic [11:0] num = '0;
  logic [11:0] den = '0;
  logic [1:0] mode = '0;
  logic [1:0] rsel = '0;
  logic [3:0] ien = 4'h3;
  logic rc = 1'b0;
  logic rc_chk = 1'b0;
  logic [1:0] sclr = 2'h0;
  logic [1:0] st;
  logic irqb;
  logic [23:0] win;
  logic [23:0] wd;
  logic cf;
  logic wv;
  int cf_cnt;
  int n_fail = 0;
  int n_checks = 0;
  logic [23:0] exp_q[$];
  logic [23:0] w_exp = '0;
  int w_per = 0;
  int w_cnt = 0;
  int last_t = -1;
  int cyc = 0;
  int cf_a;
  int cf_b;
  // Gain 800 halves the power; offset 0100 adds one sample LSB
  logic signed [23:0] t_smp [6] = '{24'h200000, 24'he00000, 24'h1fffff,
    24'h400000, 24'h200000, 24'h400000};
  logic [11:0] t_gain [6] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h800};
  logic [15:0] t_ofs [6] = '{16'h0, 16'h0, 16'h0100, 16'h0, 16'h0, 16'h0};
  logic [7:0] t_div [6] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 8'h01};
  logic [11:0] t_num [6] = '{12'h0, 12'h0, 12'h009, 12'h0, 12'hfff, 12'h001};
  logic [11:0] t_den [6] = '{12'h0, 12'h0, 12'h004, 12'h003, 12'hfff, 12'h007};
  int t_dlt [6] = '{1, -1, 1, 1, 1, 1};
  int t_cf [6] = '{16, 16, 16, 8, 16, 4};

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  aea_top #(.WAVE_PERIOD_CYC(WP)) DUT (
    .CLK_IN(clk),
    .RST_B_IN(rst_b),
    .PWR_SAMPLE_IN(smp),
    .POWER_GAIN_IN(gain),
    .POWER_OFFSET_IN(ofs),
    .ENERGY_DIVIDER_IN(dv),
    .PULSE_NUMERATOR_IN(num),
    .PULSE_DENOMINATOR_IN(den),
    .MODE_WAVE_SEL_IN(mode),
    .WAVE_RATE_SEL_IN(rsel),
    .IRQ_EN_IN(ien),
    .STATUS_CLR_IN(sclr),
    .READ_CLEAR_IN(rc),
    .ACTIVE_ENERGY_OUT(win),
    .STATUS_OUT(st),
    .IRQ_B_OUT(irqb),
    .CALIBRATION_PULSE_OUT(cf),
    .WAVE_DATA_OUT(wd),
    .WAVE_VALID_OUT(wv)
  );

  aea_cal_counter u_meter (
    .clk_in(clk),
    .rst_b_in(rst_b),
    .pulse_in(cf),
    .count_out(cf_cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_fail++;
      $display("Error t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Entered at a falling edge; the window is read in the pulse cycle
  task automatic rd_clr(input logic chk, input logic [23:0] expv);
    if (chk) begin
      exp_q.push_back(expv);
    end
    rc = 1'b1;
    rc_chk = chk;
    @(negedge clk);
    rc = 1'b0;
    rc_chk = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rc && rc_chk) begin
      check(win, exp_q.pop_front());
    end
    if (wv) begin
      // First sample after a setting change may predate it
      if (last_t >= 0) begin
        check(wd, w_exp);
        check(24'(cyc - last_t), 24'(w_per));
      end
      last_t = cyc;
      w_cnt++;
    end
  end

  initial begin
    #(20000 * 4);
    n_fail++;
    $display("Error t=%0t watchdog expired", $time);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hba01));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // Reads K ticks apart must differ by exactly K steps, whatever the tick phase
    for (int i = 0; i < 6; i++) begin
      smp = t_smp[i];
      gain = t_gain[i];
      ofs = t_ofs[i];
      dv = t_div[i];
      num = t_num[i];
      den = t_den[i];
      repeat (8) @(negedge clk);
      rd_clr(1'b0, 24'h0);
      cf_a = cf_cnt;
      // Exactly 4K update edges between clear and read hold K ticks
      repeat (4 * K) @(negedge clk);
      cf_b = cf_cnt;
      rd_clr(1'b1, 24'(K * t_dlt[i]));
      check({23'h0, (cf_b - cf_a - t_cf[i]) inside {[-1:1]}}, 24'h1);
    end
    ien = 4'hb;
    dv = 8'h01;
    // Unity gain and no offset, so the waveform equals the sample
    gain = 12'sh0;
    ofs = 16'sh0;
    for (int s = 0; s < 4; s++) begin
      rsel = 2'(s);
      w_exp = 24'($urandom);
      smp = w_exp;
      w_per = WP << s;
      last_t = -1;
      w_cnt = 0;
      repeat (4 * (WP << s) + 4) @(negedge clk);
      check({23'h0, w_cnt >= 3}, 24'h1);
    end
    rsel = 2'h0;
    mode = 2'h1;
    repeat (4) @(negedge clk);
    w_cnt = 0;
    repeat (3 * WP) @(negedge clk);
    check(24'(w_cnt), 24'h0);
    mode = 2'h0;
    ien = 4'h3;
    repeat (4) @(negedge clk);
    w_cnt = 0;
    repeat (3 * WP) @(negedge clk);
    check(24'(w_cnt), 24'h0);
    // Window never came near half scale, so no flag and no interrupt
    check({22'h0, st}, 24'h0);
    check({23'h0, irqb}, 24'h1);
    sclr = 2'h3;
    @(negedge clk);
    sclr = 2'h0;
    @(negedge clk);
    check({22'h0, st}, 24'h0);
    close_out();
  end
endmodule

`default_nettype wire
